// ### omcs_defs.vh
// Purpose: constants for the operating mode and clock select block
// Assumes: 8-bit register port, byte offsets below
// Notes: definitions only
`ifndef OMCS_DEFS_VH
`define OMCS_DEFS_VH
`define OMCS_AW 2
`define OMCS_DW 8
`define OMCS_OFS_SCC 2'h0
`define OMCS_OFS_RCC 2'h1
`define OMCS_OFS_XTC 2'h2
`define OMCS_OFS_STAT 2'h3
`define OMCS_CKS_HI 7
`define OMCS_CKS_LO 5
`define OMCS_FHS_BIT 3
`define OMCS_FSS_BIT 2
`define OMCS_FAST_OSC_IDLE_ENABLE_BIT 1
`define OMCS_SLOW_OSC_IDLE_ENABLE_BIT 0
`define OMCS_RCF_HI 3
`define OMCS_RCF_LO 2
`define OMCS_FLAG_BIT 1
`define OMCS_EN_BIT 0
`define OMCS_XTM_BIT 2
`define OMCS_SCC_RST 8'h00
`define OMCS_RCC_RST 8'h01
`define OMCS_XTC_RST 8'h00
`define OMCS_CKS_SLOW 3'h7
`define OMCS_CKS_DIV1 3'h0
`define OMCS_RCF_8M 2'h0
`define OMCS_RCF_ALT8M 2'h3
`define OMCS_DIV_W 6
`define OMCS_STABLE_CYC 16
`define OMCS_NMODE 6
`endif

// ### omcs_clk_gate.v
// Purpose: glitch-free gate for a sampled clock level
// Assumes: clk_lvl_i is already synchronised to sys_clk_i
// Notes: enable is only taken while the gated level is low
`timescale 1ns/1ps
module omcs_clk_gate
(
	input wire sys_clk_i, // system clock
	input wire nrst_i, // async reset, active low
	input wire clk_lvl_i, // clock level to gate
	input wire en_i, // requested enable
	output wire clk_o // gated clock level
);
	reg en_q;
	reg out_q;
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			en_q <= 1'b0;
			out_q <= 1'b0;
		end
		else
		begin
			// no runt pulse: switch only in the low phase
			if (!clk_lvl_i)
				en_q <= en_i;
			out_q <= clk_lvl_i & en_q;
		end
	end
	assign clk_o = out_q;
endmodule // omcs_clk_gate

// ### omcs_osc_stable.v
// Purpose: oscillator stable flag with settle counter
// Assumes: restart_i is a one-cycle pulse
// Notes: flag drops on restart or disable, sets after CYC cycles
`timescale 1ns/1ps
`include "omcs_defs.vh"
module omcs_osc_stable
#(
	parameter CYC = `OMCS_STABLE_CYC
)
(
	input wire sys_clk_i, // system clock
	input wire nrst_i, // async reset, active low
	input wire en_i, // oscillator enabled
	input wire restart_i, // restart settle time
	output wire stable_o // oscillator stable flag
);
	reg [15:0] cnt_q;
	reg flag_q;
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cnt_q <= 16'h0000;
			flag_q <= 1'b0;
		end
		else if (!en_i || restart_i)
		begin
			cnt_q <= 16'h0000;
			flag_q <= 1'b0;
		end
		else if (!flag_q)
		begin
			if (cnt_q == CYC[15:0] - 16'h0001)
				flag_q <= 1'b1;
			else
				cnt_q <= cnt_q + 16'h0001;
		end
	end
	assign stable_o = flag_q;
endmodule // omcs_osc_stable

// ### omcs_mode_ctrl.v
// Purpose: operating mode state and system clock selection
// Assumes: oscillator clocks arrive as pins, sampled on sys_clk_i
// Notes: clocks leave as sampled levels; the fast clock must stay
// well below half of sys_clk_i for the sampled copy to be faithful
`timescale 1ns/1ps
`include "omcs_defs.vh"
module omcs_mode_ctrl
#(
	parameter RC_STABLE_CYC = `OMCS_STABLE_CYC,
	parameter XT_STABLE_CYC = `OMCS_STABLE_CYC
)
(
	input wire sys_clk_i, // 40 MHz system clock
	input wire nrst_i, // async reset, active low
	input wire [`OMCS_AW-1:0] addr_i, // register address
	input wire [`OMCS_DW-1:0] wdata_i, // write data
	input wire wr_i, // write strobe
	input wire rd_i, // read strobe
	output wire [`OMCS_DW-1:0] rdata_o, // read data, cycle after rd_i
	input wire halt_i, // cpu halt strobe, one cycle
	input wire wake_i, // wake-up request
	input wire wdt_en_i, // watchdog enabled
	input wire rc_clk_i, // fast rc oscillator pin clock
	input wire xt_clk_i, // crystal oscillator pin clock
	input wire lrc_clk_i, // slow rc oscillator pin clock
	output wire cpu_run_o, // cpu clock running
	output wire [`OMCS_NMODE-1:0] mode_o, // one-hot mode
	output wire sys_clk_o, // system clock level
	output wire fast_clk_o, // undivided fast clock level
	output wire sub_clk_o, // sub clock level
	output wire lrc_clk_o, // slow rc clock level
	output wire rc_osc_en_o, // fast rc oscillator enable
	output wire xt_osc_en_o, // crystal oscillator enable
	output wire [1:0] rc_freq_o, // effective rc frequency code
	output wire xt_range_o // crystal range select
);
	localparam [5:0] ST_FAST = 6'h01;
	localparam [5:0] ST_SLOW = 6'h02;
	localparam [5:0] ST_SLEEP = 6'h04;
	localparam [5:0] ST_IDLE_SLOW = 6'h08;
	localparam [5:0] ST_IDLE_BOTH = 6'h10;
	localparam [5:0] ST_IDLE_FAST = 6'h20;

	reg [2:0] cks_q;
	reg fhs_q;
	reg fss_q;
	reg fast_osc_idle_enable_q;
	reg slow_osc_idle_enable_q;
	reg [1:0] rcf_q;
	reg rc_en_q;
	reg xtm_q;
	reg xt_en_q;
	reg [1:0] rcf_eff_q;
	reg rc_restart_q;
	reg xt_restart_q;
	reg [5:0] mode_q;
	reg [5:0] mode_d;
	reg [`OMCS_DW-1:0] rdata_q;
	reg [`OMCS_DW-1:0] rdata_d;
	reg [`OMCS_DIV_W-1:0] div_cnt_q;
	reg div_clk_q;
	reg fast_prev_q;
	reg fast_en;
	reg sub_en;
	reg lrc_en;
	wire rc_stable;
	wire xt_stable;
	wire [2:0] pin_raw = {lrc_clk_i, xt_clk_i, rc_clk_i};
	wire [2:0] pin_lvl;
	wire fast_src;
	wire fast_g;
	wire sub_g;
	wire lrc_g;
	wire sys_div_g;
	wire sys_sub_g;
	wire wr_scc = wr_i && (addr_i == `OMCS_OFS_SCC);
	wire wr_rcc = wr_i && (addr_i == `OMCS_OFS_RCC);
	wire wr_xtc = wr_i && (addr_i == `OMCS_OFS_XTC);
	wire run_mode = (mode_q == ST_FAST) || (mode_q == ST_SLOW);

	// three synchroniser flops and a level flop per pin; level moves only when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_sync
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg lvl_q;
			always @(posedge sys_clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					lvl_q <= 1'b0;
				end
				else
				begin
					s1_q <= pin_raw[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q)
						lvl_q <= s3_q;
				end
			end
			assign pin_lvl[gi] = lvl_q;
		end
	endgenerate

	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cks_q <= `OMCS_CKS_DIV1;
			fhs_q <= 1'b0;
			fss_q <= 1'b0;
			fast_osc_idle_enable_q <= 1'b0;
			slow_osc_idle_enable_q <= 1'b0;
			rcf_q <= `OMCS_RCF_8M;
			rc_en_q <= 1'b1;
			xtm_q <= 1'b0;
			xt_en_q <= 1'b0;
			rc_restart_q <= 1'b0;
			xt_restart_q <= 1'b0;
		end
		else
		begin
			rc_restart_q <= 1'b0;
			xt_restart_q <= 1'b0;
			if (wr_scc)
			begin
				cks_q <= wdata_i[`OMCS_CKS_HI:`OMCS_CKS_LO];
				fhs_q <= wdata_i[`OMCS_FHS_BIT];
				fss_q <= wdata_i[`OMCS_FSS_BIT];
				fast_osc_idle_enable_q <= wdata_i[`OMCS_FAST_OSC_IDLE_ENABLE_BIT];
				slow_osc_idle_enable_q <= wdata_i[`OMCS_SLOW_OSC_IDLE_ENABLE_BIT];
			end
			if (wr_rcc)
			begin
				rcf_q <= wdata_i[`OMCS_RCF_HI:`OMCS_RCF_LO];
				rc_en_q <= wdata_i[`OMCS_EN_BIT];
				// enabling or retuning restarts the settle time
				if ((wdata_i[`OMCS_EN_BIT] && !rc_en_q) ||
					(wdata_i[`OMCS_RCF_HI:`OMCS_RCF_LO] != rcf_q))
					rc_restart_q <= 1'b1;
			end
			if (wr_xtc)
			begin
				// range is frozen while the crystal runs
				if (!xt_en_q)
					xtm_q <= wdata_i[`OMCS_XTM_BIT];
				xt_en_q <= wdata_i[`OMCS_EN_BIT];
				if (wdata_i[`OMCS_EN_BIT] && !xt_en_q)
					xt_restart_q <= 1'b1;
			end
		end
	end

	omcs_osc_stable #(
		.CYC(RC_STABLE_CYC)
	) u_rc_stable (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.en_i(rc_en_q),
		.restart_i(rc_restart_q),
		.stable_o(rc_stable)
	);

	omcs_osc_stable #(
		.CYC(XT_STABLE_CYC)
	) u_xt_stable (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.en_i(xt_en_q),
		.restart_i(xt_restart_q),
		.stable_o(xt_stable)
	);

	// frequency code passes to the oscillator only once settled
	always @(posedge sys_clk_i or negedge nrst_i)
		if (!nrst_i)
			rcf_eff_q <= `OMCS_RCF_8M;
		else if (rc_stable && !rc_restart_q)
			rcf_eff_q <= (rcf_q == `OMCS_RCF_ALT8M) ? `OMCS_RCF_8M : rcf_q;

	always @*
	begin
		mode_d = mode_q;
		case (mode_q)
			ST_FAST, ST_SLOW:
			begin
				if (halt_i)
				begin
					// idle enables taken on the halt strobe itself
					case ({fast_osc_idle_enable_q, slow_osc_idle_enable_q})
						2'b00: mode_d = ST_SLEEP;
						2'b01: mode_d = ST_IDLE_SLOW;
						2'b11: mode_d = ST_IDLE_BOTH;
						default: mode_d = ST_IDLE_FAST;
					endcase
				end
				else if (cks_q == `OMCS_CKS_SLOW)
					mode_d = ST_SLOW;
				else
					mode_d = ST_FAST;
			end
			ST_SLEEP, ST_IDLE_SLOW, ST_IDLE_BOTH, ST_IDLE_FAST:
				if (wake_i)
					mode_d = (cks_q == `OMCS_CKS_SLOW) ? ST_SLOW : ST_FAST;
			default: mode_d = ST_FAST;
		endcase
	end

	always @(posedge sys_clk_i or negedge nrst_i)
		if (!nrst_i)
			mode_q <= ST_FAST;
		else
			mode_q <= mode_d;

	// clock needs per mode
	always @*
	begin
		fast_en = 1'b0;
		sub_en = 1'b0;
		lrc_en = 1'b1;
		case (mode_q)
			ST_FAST, ST_IDLE_BOTH:
			begin
				fast_en = 1'b1;
				sub_en = 1'b1;
			end
			ST_SLOW:
			begin
				fast_en = fhs_q ? xt_en_q : rc_en_q;
				sub_en = 1'b1;
			end
			ST_SLEEP: lrc_en = wdt_en_i;
			ST_IDLE_SLOW: sub_en = 1'b1;
			ST_IDLE_FAST: fast_en = 1'b1;
			default: fast_en = 1'b0;
		endcase
	end

	// fast source select: 1 crystal, 0 fast rc
	assign fast_src = fhs_q ? pin_lvl[1] : pin_lvl[0];

	omcs_clk_gate u_fast_gate (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_lvl_i(fast_src),
		.en_i(fast_en),
		.clk_o(fast_g)
	);

	// sub clock always from the slow rc; select bit kept for software only
	omcs_clk_gate u_sub_gate (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_lvl_i(pin_lvl[2]),
		.en_i(sub_en),
		.clk_o(sub_g)
	);

	omcs_clk_gate u_lrc_gate (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_lvl_i(pin_lvl[2]),
		.en_i(lrc_en),
		.clk_o(lrc_g)
	);

	// ripple of powers of two; bit k gives divide by 2^(k+1)
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			fast_prev_q <= 1'b0;
			div_cnt_q <= {`OMCS_DIV_W{1'b0}};
			div_clk_q <= 1'b0;
		end
		else
		begin
			fast_prev_q <= fast_g;
			if (fast_g && !fast_prev_q)
				div_cnt_q <= div_cnt_q + {{(`OMCS_DIV_W-1){1'b0}}, 1'b1};
			if (cks_q == `OMCS_CKS_DIV1)
				div_clk_q <= fast_g;
			else if (cks_q != `OMCS_CKS_SLOW)
				div_clk_q <= div_cnt_q[cks_q - 3'h1];
			else
				div_clk_q <= 1'b0;
		end
	end

	// cpu clock: divided fast in fast mode, sub clock in slow mode
	omcs_clk_gate u_sys_div_gate (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_lvl_i(div_clk_q),
		.en_i(mode_q == ST_FAST),
		.clk_o(sys_div_g)
	);

	omcs_clk_gate u_sys_sub_gate (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_lvl_i(sub_g),
		.en_i(mode_q == ST_SLOW),
		.clk_o(sys_sub_g)
	);

	assign sys_clk_o = sys_div_g | sys_sub_g;
	assign fast_clk_o = fast_g;
	assign sub_clk_o = sub_g;
	assign lrc_clk_o = lrc_g;
	assign cpu_run_o = run_mode;
	assign mode_o = mode_q;
	// oscillators only run while some clock consumer needs them
	assign rc_osc_en_o = rc_en_q && fast_en && !fhs_q;
	assign xt_osc_en_o = xt_en_q && fast_en && fhs_q;
	assign rc_freq_o = rcf_eff_q;
	assign xt_range_o = xtm_q;

	always @*
	begin
		rdata_d = {`OMCS_DW{1'b0}};
		case (addr_i)
			`OMCS_OFS_SCC: rdata_d = {cks_q, 1'b0, fhs_q, fss_q, fast_osc_idle_enable_q, slow_osc_idle_enable_q};
			`OMCS_OFS_RCC: rdata_d = {4'h0, rcf_q, rc_stable, rc_en_q};
			`OMCS_OFS_XTC: rdata_d = {5'h00, xtm_q, xt_stable, xt_en_q};
			`OMCS_OFS_STAT: rdata_d = {2'h0, mode_q};
			default: rdata_d = {`OMCS_DW{1'b0}};
		endcase
	end

	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rdata_q <= {`OMCS_DW{1'b0}};
		else
			rdata_q <= rd_i ? rdata_d : {`OMCS_DW{1'b0}};
	end
	assign rdata_o = rdata_q;
endmodule // omcs_mode_ctrl

// ### omcs_props.sv
// Purpose: port checks for omcs_mode_ctrl
// Assumes: no halt or wake in the same cycle as a control write
// Notes: keeps its own copy of the control register
`timescale 1ns/1ps
module omcs_props
(
	input wire sys_clk_i, // clock
	input wire nrst_i, // reset
	input wire [1:0] addr_i, // address
	input wire [7:0] wdata_i, // data
	input wire wr_i, // write
	input wire halt_i, // halt
	input wire wake_i, // wake
	input wire wdt_en_i, // watchdog
	input wire cpu_run_o, // cpu on
	input wire [5:0] mode_o, // mode
	input wire fast_clk_o, // fast
	input wire sub_clk_o, // sub
	input wire lrc_clk_o, // slow rc
	input wire [1:0] rc_freq_o // rc code
);
	reg [7:0] scc_q;
	reg [5:0] mode_q;
	reg [4:0] age_q;
	wire old = &age_q;
	wire [5:0] idle = scc_q[1] ? (scc_q[0] ? 6'h10 : 6'h20) : (scc_q[0] ? 6'h08 : 6'h04);
	wire [5:0] run = scc_q[7:5] == 3'h7 ? 6'h02 : 6'h01;
	// age lets a gate wait out a high phase and the pin synchroniser
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			scc_q <= 8'h00;
			mode_q <= 6'h01;
			age_q <= 5'h00;
		end
		else
		begin
			if (wr_i && addr_i == 2'h0)
				scc_q <= wdata_i;
			mode_q <= mode_o;
			age_q <= mode_o != mode_q ? 5'h00 : age_q + {4'h0, !old};
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// scc_q holds the written divider code two edges on
	property p_div;
		wr_i && addr_i == 2'h0 && cpu_run_o |-> ##2 mode_o == run;
	endproperty
	a_run_decode: assert property (cpu_run_o == |mode_o[1:0])
		else $error("cpu run flag");
	a_mode_onehot: assert property ($onehot(mode_o))
		else $error("mode not one-hot");
	a_halt_entry: assert property (halt_i && cpu_run_o |=> mode_o == idle)
		else $error("halt mode");
	a_halt_hold: assert property (!cpu_run_o && !wake_i |=> $stable(mode_o))
		else $error("low power left");
	a_wake_run: assert property (!cpu_run_o && wake_i |=> mode_o == run)
		else $error("wake mode");
	a_div_mode: assert property (p_div)
		else $error("divider mode");
	a_sleep_off: assert property (mode_o[2] && old |-> !fast_clk_o && !sub_clk_o)
		else $error("sleep clock");
	a_sleep_lrc: assert property (mode_o[2] && old && !wdt_en_i |-> !lrc_clk_o)
		else $error("sleep slow rc");
	a_idle_gate: assert property (old |->
		!(mode_o[3] && fast_clk_o) && !(mode_o[5] && sub_clk_o))
		else $error("idle clock");
	a_gate_pulse: assert property ($rose(sub_clk_o) |=> sub_clk_o)
		else $error("sub clock runt");
	a_rc_code: assert property (rc_freq_o != 2'h3)
		else $error("rc code");
	c_both: cover property (mode_o == 6'h10);
	c_slow: cover property (mode_o == 6'h02);
	c_wake: cover property (!cpu_run_o && wake_i);
endmodule // omcs_props
bind omcs_mode_ctrl omcs_props u_props (.sys_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .halt_i,
	.wake_i, .wdt_en_i, .cpu_run_o, .mode_o, .fast_clk_o, .sub_clk_o, .lrc_clk_o, .rc_freq_o);

// ### omcs_cpu_model.sv
// Purpose: cpu core side: register port and halt or wake strobes
// Assumes: one request at a time, launched after a rising edge
// Notes: read data taken in the cycle after the strobe
`timescale 1ns/1ps
module omcs_cpu_model
(
	input wire sys_clk_i, // clock
	input wire [7:0] rdata_i, // read data
	output reg [1:0] addr_o, // address
	output reg [7:0] wdata_o, // write data
	output reg wr_o, // write strobe
	output reg rd_o, // read strobe
	output reg halt_o, // halt strobe
	output reg wake_o // wake request
);
	// idle bus from time zero, so reset sees no unknown strobe
	initial
	begin
		addr_o <= 2'h0;
		wdata_o <= 8'h00;
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		halt_o <= 1'b0;
		wake_o <= 1'b0;
	end
	task wr(input logic [1:0] a, input logic [7:0] d);
	begin
		@(posedge sys_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge sys_clk_i);
		wr_o <= 1'b0;
	end
	endtask
	task rd(input logic [1:0] a, output logic [7:0] d);
	begin
		@(posedge sys_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge sys_clk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	end
	endtask
	task pulse(input logic w);
	begin
		@(posedge sys_clk_i);
		if (w)
			wake_o <= 1'b1;
		else
			halt_o <= 1'b1;
		@(posedge sys_clk_i);
		wake_o <= 1'b0;
		halt_o <= 1'b0;
	end
	endtask
endmodule // omcs_cpu_model

// ### tb_top.sv
// Purpose: self-checking bench for the mode and clock select block
// Assumes: oscillator pins run free, far slower than sys_clk_i
// Notes: settle counts cut to 4 cycles
`timescale 1ns/1ps
module tb_top;
	logic sys_clk_i = 0, rc_clk_i = 0, xt_clk_i = 0, lrc_clk_i = 0, nrst_i, wdt_en_i;
	wire [1:0] addr_i, rc_freq_o;
	wire [7:0] wdata_i, rdata_o;
	wire [5:0] mode_o;
	wire wr_i, rd_i, halt_i, wake_i, cpu_run_o, sys_clk_o, fast_clk_o, sub_clk_o, lrc_clk_o;
	wire rc_osc_en_o, xt_osc_en_o, xt_range_o;
	int bad_count = 0, total_checks = 0, ns, nf, nb, nl;
	localparam logic [9:0] IB = {2'h0, 2'h2, 2'h3, 2'h1, 2'h0};
	localparam logic [29:0] EM = {6'h04, 6'h20, 6'h10, 6'h08, 6'h04};
	localparam logic [14:0] ON = {5'b11110, 5'b00110, 5'b01100}; // slow rc, sub, fast
	localparam logic [31:0] RST = {8'h01, 8'h00, 8'h03, 8'h00};
	always #12.5 sys_clk_i = ~sys_clk_i;
	always #100 rc_clk_i = ~rc_clk_i;
	always #75 xt_clk_i = ~xt_clk_i;
	always #125 lrc_clk_i = ~lrc_clk_i;
	omcs_mode_ctrl #(.RC_STABLE_CYC(4), .XT_STABLE_CYC(4)) dut (.sys_clk_i, .nrst_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .halt_i, .wake_i, .wdt_en_i, .rc_clk_i, .xt_clk_i,
		.lrc_clk_i, .cpu_run_o, .mode_o, .sys_clk_o, .fast_clk_o, .sub_clk_o, .lrc_clk_o,
		.rc_osc_en_o, .xt_osc_en_o, .rc_freq_o, .xt_range_o);
	omcs_cpu_model cpu (.sys_clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
		.wr_o(wr_i), .rd_o(rd_i), .halt_o(halt_i), .wake_o(wake_i));
	task chk(input string s, input logic [31:0] v, input logic [31:0] e);
	begin
		total_checks++;
		if (v !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", s, e, v);
		end
	end
	endtask
	// edge counts drift by phase, so allow two either way
	task chkn(input string s, input int v, input int e);
	begin
		chk(s, (v >= e - 2 && v <= e + 2) ? e : v, e);
	end
	endtask
	task step(input int n);
	begin
		repeat (n) @(posedge sys_clk_i);
		#1;
	end
	endtask
	task meas(input int n);
		logic [3:0] p;
	begin
		{ns, nf, nb, nl} = 0;
		p = {sys_clk_o, fast_clk_o, sub_clk_o, lrc_clk_o};
		repeat (n)
		begin
			step(1);
			ns += int'(sys_clk_o & ~p[3]);
			nf += int'(fast_clk_o & ~p[2]);
			nb += int'(sub_clk_o & ~p[1]);
			nl += int'(lrc_clk_o & ~p[0]);
			p = {sys_clk_o, fast_clk_o, sub_clk_o, lrc_clk_o};
		end
	end
	endtask
	task t_reset;
		logic [7:0] d;
	begin
		step(8);
		for (int a = 0; a < 4; a++)
		begin
			cpu.rd(a[1:0], d);
			chk("reset value", d, RST[8*a +: 8]);
		end
		cpu.wr(2'h0, 8'hff);
		cpu.wr(2'h3, 8'h3f);
		cpu.rd(2'h0, d);
		chk("ctrl", d, 8'hef);
		step(2);
		cpu.rd(2'h3, d);
		chk("status", d, 8'h02);
		cpu.wr(2'h0, 8'h00);
		$display("t_reset done");
	end
	endtask
	task t_modes;
	begin
		for (int i = 0; i < 5; i++)
		begin
			@(posedge sys_clk_i) wdt_en_i <= (i == 4);
			cpu.wr(2'h0, {6'h00, IB[2*i +: 2]});
			cpu.pulse(1'b0);
			step(2);
			chk("halt mode", mode_o, EM[6*i +: 6]);
			chk("cpu off", cpu_run_o, 1'b0);
			// idle bits flipped after entry must not matter
			cpu.wr(2'h0, {6'h00, ~IB[2*i +: 2]});
			cpu.pulse(1'b0);
			step(30);
			chk("held", mode_o, EM[6*i +: 6]);
			meas(64);
			chk("fast", nf != 0, ON[i]);
			chk("sub", nb != 0, ON[5+i]);
			chk("slow rc", nl != 0, ON[10+i]);
			chk("rc osc", rc_osc_en_o, ON[i]);
			cpu.pulse(1'b1);
			step(2);
			chk("woken", mode_o, 6'h01);
		end
		cpu.pulse(1'b1);
		step(2);
		chk("wake in run", mode_o, 6'h01);
		$display("t_modes done");
	end
	endtask
	task t_div;
	begin
		for (int k = 0; k < 8; k++)
		begin
			cpu.wr(2'h0, {k[2:0], 5'h00});
			step(40);
			meas(2048);
			if (k < 7)
				chkn("divided", ns, 256 >> k);
			else
				chkn("sub sys", ns, 205);
		end
		chk("slow", mode_o, 6'h02);
		chk("fast in slow", nf != 0, 1'b1);
		cpu.wr(2'h1, 8'h00);
		step(40);
		meas(64);
		chk("fast stopped", nf, 0);
		cpu.wr(2'h1, 8'h01);
		cpu.wr(2'h0, 8'h00);
		step(20);
		$display("t_div done");
	end
	endtask
	task t_osc;
		logic [7:0] d;
		logic [1:0] c;
		logic [1:0] p;
	begin
		p = 2'h0;
		for (int i = 1; i < 5; i++)
		begin
			c = i[1:0];
			cpu.wr(2'h1, {4'h0, c, 2'h1});
			step(2);
			cpu.rd(2'h1, d);
			chk("rc settling", d, {4'h0, c, 2'h1});
			chk("rc old code", rc_freq_o, p);
			step(10);
			cpu.rd(2'h1, d);
			chk("rc stable", d, {4'h0, c, 2'h3});
			p = (c == 2'h3) ? 2'h0 : c;
			chk("rc code", rc_freq_o, p);
		end
		cpu.wr(2'h2, 8'h04);
		cpu.wr(2'h2, 8'h05);
		step(2);
		cpu.rd(2'h2, d);
		chk("xt settling", d, 8'h05);
		step(10);
		cpu.wr(2'h2, 8'h01);
		cpu.rd(2'h2, d);
		chk("xt stable", d, 8'h07);
		chk("xt range", xt_range_o, 1'b1);
		cpu.wr(2'h0, 8'h08);
		step(40);
		meas(2048);
		chkn("crystal sys", ns, 341);
		chk("xt osc", xt_osc_en_o, 1'b1);
		chk("rc osc off", rc_osc_en_o, 1'b0);
		$display("t_osc done");
	end
	endtask
	task conclude;
	begin
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	initial
	begin
		nrst_i <= 1'b0;
		wdt_en_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		t_reset;
		t_modes;
		t_div;
		t_osc;
		conclude;
	end
	initial
	begin
		#2000000;
		bad_count++;
		conclude;
	end
endmodule // tb_top
